// ---- irq_consts.svh ----
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

// Register byte offsets on the Avalon-MM slave
`define OFS_IRQ_ENABLE 8'h00
`define OFS_EXT_ENABLE 8'h04
`define OFS_PRIO_BASE 8'h08
`define OFS_PRIO_EXT 8'h0C
`define OFS_PENDING 8'h10
`define OFS_PIN_CONFIG 8'h14
`define OFS_STATUS 8'h18

// Field positions
`define BIT_GLOBAL_EN 7
`define BIT_A_SENSE 0
`define BIT_B_SENSE 1
`define BIT_A_POL 2
`define BIT_B_POL 3
`define SRC_EXT_A 0
`define SRC_TIMER_A 1
`define SRC_EXT_B 2
`define SRC_TIMER_B 3

// Reset values
`define RST_BYTE 8'h00
`define RST_PENDING 14'h0000
`define RST_CONFIG 4'h0

// Vector layout: first vector, spacing, and the one unused vector slot
`define VEC_BASE 16'h0003
`define VEC_STEP 16'h0008
`define VEC_HOLE 4'h8

`endif

// ---- irq_pkg.sv ----
package irq_pkg;
    typedef logic [13:0] src_vec_t;
    typedef logic [3:0] src_idx_t;
    typedef logic [1:0] ext_pair_t;
endpackage

// ---- ext_irq_detect.sv ----
`timescale 1ns/1ps
module ext_irq_detect
(
    input wire logic mclk, // System clock
    input wire logic rst, // Asynchronous reset, active high
    input wire irq_pkg::ext_pair_t pinIn, // Raw external pins, unsynchronised
    input wire irq_pkg::ext_pair_t polarity, // 1 active high, 0 active low
    output irq_pkg::ext_pair_t levelActive, // Synchronised input at its active level
    output irq_pkg::ext_pair_t edgeEvent // One-cycle pulse on entering active level
);
    import irq_pkg::*;

    typedef struct packed {
        ext_pair_t syncA;
        ext_pair_t syncB;
        ext_pair_t prevAct;
    } det_state_t;

    det_state_t cur_ff;
    det_state_t nxt_ff;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_ch
            // Only the second sync stage feeds the polarity and edge logic
            assign levelActive[ch] = ~(cur_ff.syncB[ch] ^ polarity[ch]); // R22
            assign edgeEvent[ch] = levelActive[ch] & ~cur_ff.prevAct[ch]; // R22
        end
    endgenerate

    always_comb
    begin
        nxt_ff = cur_ff;
        // Pins are only sampled, never driven, so crossbar users are undisturbed
        nxt_ff.syncA = pinIn; // R14
        nxt_ff.syncB = cur_ff.syncA;
        nxt_ff.prevAct = levelActive;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            // Sync stages start at the idle level of an active-low pin, so no
            // false edge or level pulse follows reset
            cur_ff <= '{syncA: 2'h3, syncB: 2'h3, prevAct: 2'h0};
        end
        else
        begin
            cur_ff <= nxt_ff;
        end
    end
endmodule

// ---- irq_priority_arbiter.sv ----
`timescale 1ns/1ps
module irq_priority_arbiter
(
    input wire irq_pkg::src_vec_t reqVec, // Enabled and pending sources
    input wire irq_pkg::src_vec_t prioHigh, // Per-source high-priority select
    input wire logic allowLow, // Low-priority requests may be taken
    input wire logic allowHigh, // High-priority requests may be taken
    output logic winValid, // Some request wins
    output irq_pkg::src_idx_t winIdx, // Winning source index
    output logic winHigh // Winner is high priority
);
    import irq_pkg::*;

    src_vec_t hiReq;
    src_vec_t loReq;

    assign hiReq = reqVec & prioHigh & {14{allowHigh}};
    assign loReq = reqVec & ~prioHigh & {14{allowLow}};

    always_comb
    begin
        winValid = 1'b0;
        winIdx = 4'h0;
        winHigh = 1'b0;
        // High level first, then lowest index within a level
        if (|hiReq) // R20
        begin
            winValid = 1'b1;
            winHigh = 1'b1;
            for (int i = 13; i >= 0; i--)
            begin
                if (hiReq[i])
                begin
                    winIdx = 4'(i); // R20
                end
            end
        end
        else if (|loReq)
        begin
            winValid = 1'b1;
            for (int i = 13; i >= 0; i--)
            begin
                if (loReq[i])
                begin
                    winIdx = 4'(i); // R20
                end
            end
        end
    end
endmodule

// ---- cpu_interrupt_handler.sv ----
// Function
// R1: Fourteen sources, pending flags, two priority levels.
// R2: Pending flag sets regardless of any enable.
// R3: Enabled pending source requests a long call vector.
// R4: Return resumes the interrupted instruction stream.
// R5: Disabled pending flags raise no request.
// R6: Every source has its own enable bit.
// R7: Global enable bit 7 gates all sources.
// R8: Global clear may still let one request through.
// R9: Software follows global clear with two-byte opcode.
// R10: Some flags hardware-cleared on vectoring, others software.
// R11: Flag set after return re-requests after one instruction.
// R12: Software writing one to a flag mimics events.
// R13: Sense and polarity bits pick four external modes.
// R14: External inputs watch pins without disturbing crossbar.
// R15: External pending flags: timer control bits 1, 3; here pending register bits 0, 2.
// R16: Edge-mode external flag cleared on vectoring.
// R17: Level-mode external flag tracks the active input.
// R18: Level source holds until recognised, releases before return.
// R19: High preempts low; nothing preempts high; default low.
// R20: Higher priority first, ties by fixed source order.
// R21: Requests sampled every cycle, five-cycle best response.
// R22: External inputs synchronised before edge or level detection.
// R23: Reset clears flags, enables and configuration.
`timescale 1ns/1ps
`include "irq_consts.svh"
module cpu_interrupt_handler
(
    input wire logic mclk, // System clock, 25 MHz
    input wire logic rst, // Asynchronous reset, active high
    input wire logic [7:0] address, // Avalon byte address
    input wire logic read, // Avalon read request
    input wire logic write, // Avalon write request
    input wire logic [31:0] writedata, // Avalon write data
    input wire logic [3:0] byteenable, // Avalon byte enables
    output logic [31:0] readdata, // Avalon read data
    output logic waitrequest, // Avalon wait, low for the accepting cycle
    input wire irq_pkg::src_vec_t srcEvent, // Peripheral event pulses, same clock
    input wire logic extIrqA, // External interrupt pin A
    input wire logic extIrqB, // External interrupt pin B
    input wire logic instrDone, // Core: an instruction completed
    input wire logic irqAck, // Core: vectoring to the presented vector
    input wire logic retiDone, // Core: return from interrupt completed
    output logic irqRequest, // Request to core, taken at an instruction end
    output logic [15:0] irqVector, // Long call target for the request
    output logic irqHighLevel // Presented request is high priority
);
    import irq_pkg::*;

    typedef struct packed {
        logic [7:0] irqEnable;
        logic [7:0] extEnable;
        logic [7:0] prioBase;
        logic [7:0] prioExt;
        src_vec_t pending;
        logic [3:0] pinCfg;
        logic inServiceLow;
        logic inServiceHigh;
        logic holdAfterReti;
        logic req;
        src_idx_t reqIdx;
        logic reqHigh;
        logic [15:0] vector;
        logic waitReq;
        logic [31:0] rdata;
    } hdl_state_t;

    hdl_state_t cur_ff;
    hdl_state_t nxt_ff;

    ext_pair_t extLevel;
    ext_pair_t extEdge;
    ext_pair_t extSense;
    src_vec_t enableVec;
    src_vec_t prioVec;
    src_vec_t maskedReq;
    logic winValid;
    src_idx_t winIdx;
    logic winHigh;
    logic busWrite;
    logic busRead;
    logic [31:0] rdMux;
    logic [31:0] beMask;

    assign extSense = {cur_ff.pinCfg[`BIT_B_SENSE], cur_ff.pinCfg[`BIT_A_SENSE]};

    ext_irq_detect u_detect
    (
        .mclk(mclk),
        .rst(rst),
        .pinIn({extIrqB, extIrqA}),
        .polarity({cur_ff.pinCfg[`BIT_B_POL], cur_ff.pinCfg[`BIT_A_POL]}), // R13
        .levelActive(extLevel),
        .edgeEvent(extEdge)
    );

    // One enable and one priority bit per source, low byte first
    assign enableVec = {cur_ff.extEnable[6:0], cur_ff.irqEnable[6:0]}; // R6
    assign prioVec = {cur_ff.prioExt[6:0], cur_ff.prioBase[6:0]};
    // Pending alone never requests; both enables must agree
    assign maskedReq = cur_ff.pending & enableVec
        & {14{cur_ff.irqEnable[`BIT_GLOBAL_EN]}}; // R5 R7

    irq_priority_arbiter u_arb
    (
        .reqVec(maskedReq),
        .prioHigh(prioVec),
        .allowLow(~cur_ff.inServiceLow & ~cur_ff.inServiceHigh), // R19
        .allowHigh(~cur_ff.inServiceHigh), // R19
        .winValid(winValid),
        .winIdx(winIdx),
        .winHigh(winHigh)
    );

    // Writes accept on the cycle the master sees waitrequest low; reads sample in the wait cycle before it
    assign busWrite = write & ~cur_ff.waitReq;
    assign busRead = read & cur_ff.waitReq;

    always_comb
    begin
        beMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
            {8{byteenable[1]}}, {8{byteenable[0]}}};
    end

    always_comb
    begin
        rdMux = 32'h00000000;
        case (address)
            `OFS_IRQ_ENABLE: rdMux = {24'h000000, cur_ff.irqEnable};
            `OFS_EXT_ENABLE: rdMux = {24'h000000, cur_ff.extEnable};
            `OFS_PRIO_BASE: rdMux = {24'h000000, cur_ff.prioBase};
            `OFS_PRIO_EXT: rdMux = {24'h000000, cur_ff.prioExt};
            `OFS_PENDING: rdMux = {18'h00000, cur_ff.pending};
            `OFS_PIN_CONFIG: rdMux = {28'h0000000, cur_ff.pinCfg};
            `OFS_STATUS: rdMux = {21'h000000, extLevel, cur_ff.reqIdx,
                cur_ff.reqHigh, cur_ff.req, cur_ff.inServiceHigh,
                cur_ff.inServiceLow, cur_ff.holdAfterReti};
            default: rdMux = 32'h00000000;
        endcase
    end

    always_comb
    begin
        logic [31:0] wr;
        src_vec_t hwClear;
        src_vec_t hwSet;
        logic [4:0] order;
        wr = 32'h00000000;
        hwClear = '0;
        hwSet = '0;
        order = 5'h00;
        nxt_ff = cur_ff;

        // Bus handshake: one wait cycle, then one accepting cycle
        if ((read | write) & cur_ff.waitReq)
        begin
            nxt_ff.waitReq = 1'b0;
        end
        else
        begin
            nxt_ff.waitReq = 1'b1;
        end
        if (busRead)
        begin
            nxt_ff.rdata = rdMux;
        end

        if (busWrite)
        begin
            case (address)
                `OFS_IRQ_ENABLE:
                begin
                    wr = ({24'h000000, cur_ff.irqEnable} & ~beMask) | (writedata & beMask);
                    nxt_ff.irqEnable = wr[7:0]; // R7
                end
                `OFS_EXT_ENABLE:
                begin
                    wr = ({24'h000000, cur_ff.extEnable} & ~beMask) | (writedata & beMask);
                    nxt_ff.extEnable = {1'b0, wr[6:0]}; // R6
                end
                `OFS_PRIO_BASE:
                begin
                    wr = ({24'h000000, cur_ff.prioBase} & ~beMask) | (writedata & beMask);
                    nxt_ff.prioBase = {1'b0, wr[6:0]};
                end
                `OFS_PRIO_EXT:
                begin
                    wr = ({24'h000000, cur_ff.prioExt} & ~beMask) | (writedata & beMask);
                    nxt_ff.prioExt = {1'b0, wr[6:0]};
                end
                `OFS_PENDING:
                begin
                    // A written one is a real request, software clears with zero
                    wr = ({18'h00000, cur_ff.pending} & ~beMask) | (writedata & beMask);
                    nxt_ff.pending = wr[13:0]; // R12
                end
                `OFS_PIN_CONFIG:
                begin
                    wr = ({28'h0000000, cur_ff.pinCfg} & ~beMask) | (writedata & beMask);
                    nxt_ff.pinCfg = wr[3:0]; // R13
                end
                default:
                begin
                    wr = 32'h00000000;
                end
            endcase
        end

        // Vectoring clears only the timer flags and edge-mode external flags
        if (irqAck)
        begin
            if (cur_ff.reqIdx == 4'(`SRC_TIMER_A) || cur_ff.reqIdx == 4'(`SRC_TIMER_B))
            begin
                hwClear[cur_ff.reqIdx] = 1'b1; // R10
            end
            if (cur_ff.reqIdx == 4'(`SRC_EXT_A) && extSense[0])
            begin
                hwClear[`SRC_EXT_A] = 1'b1; // R16
            end
            if (cur_ff.reqIdx == 4'(`SRC_EXT_B) && extSense[1])
            begin
                hwClear[`SRC_EXT_B] = 1'b1; // R16
            end
        end

        // Events set flags whatever the enables; set beats a same-cycle clear
        hwSet = srcEvent; // R2
        hwSet[`SRC_EXT_A] = extSense[0] & extEdge[0]; // R13
        hwSet[`SRC_EXT_B] = extSense[1] & extEdge[1]; // R13
        nxt_ff.pending = (nxt_ff.pending & ~hwClear) | hwSet; // R2 R15

        // Level mode: flag simply follows the synchronised active level
        if (!extSense[0])
        begin
            nxt_ff.pending[`SRC_EXT_A] = extLevel[0]; // R17
        end
        if (!extSense[1])
        begin
            nxt_ff.pending[`SRC_EXT_B] = extLevel[1]; // R17
        end

        // In-service tracking; a high level entry always nests over low
        if (irqAck)
        begin
            if (cur_ff.reqHigh)
            begin
                nxt_ff.inServiceHigh = 1'b1; // R19
            end
            else
            begin
                nxt_ff.inServiceLow = 1'b1;
            end
        end
        else if (retiDone)
        begin
            if (cur_ff.inServiceHigh)
            begin
                nxt_ff.inServiceHigh = 1'b0; // R4
            end
            else
            begin
                nxt_ff.inServiceLow = 1'b0; // R4
            end
        end

        // After a return, one further instruction runs before re-entry
        if (retiDone)
        begin
            nxt_ff.holdAfterReti = 1'b1; // R11
        end
        else if (instrDone)
        begin
            nxt_ff.holdAfterReti = 1'b0; // R11
        end

        // Decoded every cycle from registered state, so a global clear
        // still shows a request for one cycle; software guards against it
        nxt_ff.req = winValid & ~cur_ff.holdAfterReti & ~retiDone & ~irqAck; // R3 R8 R21
        if (winValid)
        begin
            nxt_ff.reqIdx = winIdx;
            nxt_ff.reqHigh = winHigh;
            order = (winIdx < `VEC_HOLE) ? {1'b0, winIdx} : 5'({1'b0, winIdx} + 5'h01);
            nxt_ff.vector = `VEC_BASE + 16'({11'h000, order} * `VEC_STEP); // R3 R1
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cur_ff.irqEnable <= `RST_BYTE; // R23
            cur_ff.extEnable <= `RST_BYTE;
            cur_ff.prioBase <= `RST_BYTE; // R19
            cur_ff.prioExt <= `RST_BYTE;
            cur_ff.pending <= `RST_PENDING; // R23
            cur_ff.pinCfg <= `RST_CONFIG;
            cur_ff.inServiceLow <= 1'b0;
            cur_ff.inServiceHigh <= 1'b0;
            cur_ff.holdAfterReti <= 1'b0;
            cur_ff.req <= 1'b0;
            cur_ff.reqIdx <= 4'h0;
            cur_ff.reqHigh <= 1'b0;
            cur_ff.vector <= `VEC_BASE;
            cur_ff.waitReq <= 1'b1;
            cur_ff.rdata <= 32'h00000000;
        end
        else
        begin
            cur_ff <= nxt_ff;
        end
    end

    assign readdata = cur_ff.rdata;
    assign waitrequest = cur_ff.waitReq;
    assign irqRequest = cur_ff.req;
    assign irqVector = cur_ff.vector;
    assign irqHighLevel = cur_ff.reqHigh;
endmodule

// ---- cpu_interrupt_handler_assertions.sv ----
`timescale 1ns/1ps
module cpu_interrupt_handler_assertions
(
    input wire logic mclk, // Clock
    input wire logic rst, // Reset
    input wire logic [7:0] address, // Bus address
    input wire logic read, // Bus read
    input wire logic write, // Bus write
    input wire logic [31:0] writedata, // Bus data
    input wire logic [3:0] byteenable, // Lanes
    input wire logic waitrequest, // Bus wait
    input wire logic instrDone, // Core step
    input wire logic irqAck, // Core ack
    input wire logic retiDone, // Core return
    input wire logic irqRequest, // Request
    input wire logic [15:0] irqVector, // Vector
    input wire logic irqHighLevel // Priority
);
    logic glbOn_ff;
    logic inHigh_ff;
    logic inLow_ff;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            glbOn_ff <= 1'b0;
            inHigh_ff <= 1'b0;
            inLow_ff <= 1'b0;
        end
        else
        begin
            if (write && !waitrequest && address == 8'h00 && byteenable[0])
                glbOn_ff <= writedata[7];
            // A high routine always sits on top, so a return closes it first
            if (irqAck && irqHighLevel)
                inHigh_ff <= 1'b1;
            else if (irqAck)
                inLow_ff <= 1'b1;
            else if (retiDone && inHigh_ff)
                inHigh_ff <= 1'b0;
            else if (retiDone)
                inLow_ff <= 1'b0;
        end
    end
    sequence s_access;
        (read || write) && waitrequest;
    endsequence
    sequence s_return_from_irq_idle;
        retiDone ##1 !instrDone;
    endsequence
    chk_wait_one: assert property (s_access |=> !waitrequest)
        else $error("no answer one cycle after request");
    chk_wait_pulse: assert property (!waitrequest |=> waitrequest)
        else $error("wait low for more than one cycle");
    chk_reset_quiet: assert property ($fell(rst) |-> !irqRequest && waitrequest)
        else $error("outputs not idle after reset");
    chk_ack_drop: assert property (irqAck |=> !irqRequest)
        else $error("request kept after ack");
    chk_vec_shape: assert property (irqRequest |-> irqVector[2:0] == 3'h3 &&
        irqVector != 16'h0043 && irqVector <= 16'h0073)
        else $error("vector out of table");
    chk_global_gate: assert property (!glbOn_ff [*3] |-> !irqRequest)
        else $error("request with global enable off");
    chk_high_alone: assert property (inHigh_ff |-> !irqRequest)
        else $error("request during high routine");
    chk_low_preempt: assert property (inLow_ff && irqRequest |-> irqHighLevel)
        else $error("low request during low routine");
    chk_return_from_irq_hold: assert property (s_return_from_irq_idle |=> !irqRequest)
        else $error("request before next instruction");
endmodule

bind cpu_interrupt_handler cpu_interrupt_handler_assertions i_chk (.mclk, .rst, .address,
    .read, .write, .writedata, .byteenable, .waitrequest, .instrDone, .irqAck, .retiDone,
    .irqRequest, .irqVector, .irqHighLevel);

// ---- core_model.sv ----
`timescale 1ns/1ps
module core_model
#(
    parameter int SVC = 4
)
(
    input wire logic mclk, // Clock
    input wire logic rst, // Reset
    input wire logic irqRequest, // Handler request
    input wire logic ackEn, // Core may take requests
    output logic instrDone, // Instruction end
    output logic irqAck, // Vectoring
    output logic retiDone // Return done
);
    logic [1:0] phase;
    logic [1:0] depth;
    logic [7:0] left;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            phase <= 2'h0;
            depth <= 2'h0;
            left <= 8'h00;
            instrDone <= 1'b0;
            irqAck <= 1'b0;
            retiDone <= 1'b0;
        end
        else
        begin
            // Three-cycle instructions: a slow core, so lags show up
            phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
            instrDone <= (phase == 2'h2);
            irqAck <= 1'b0;
            retiDone <= 1'b0;
            if (instrDone && irqRequest && ackEn)
            begin
                irqAck <= 1'b1;
                depth <= depth + 2'h1;
                left <= 8'(SVC);
            end
            else if (instrDone && depth != 2'h0 && left != 8'h00)
                left <= left - 8'h01;
            else if (instrDone && depth != 2'h0)
            begin
                retiDone <= 1'b1;
                depth <= depth - 2'h1;
                left <= 8'(SVC);
            end
        end
    end
endmodule

// ---- cpu_interrupt_handler_tb_top.sv ----
`timescale 1ns/1ps
`define CMP(g, e) begin checked++; if ((g) !== (e)) begin failCount++; \
    $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module cpu_interrupt_handler_tb_top;
    import irq_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} reg_row_t;
    typedef struct {logic [7:0] e0; logic [7:0] e1; logic [7:0] p0; logic [31:0] pend;
        logic [15:0] vec; logic high;} vec_row_t;
    logic mclk, rst, read, write, waitrequest, extIrqA, extIrqB, ackEn;
    logic instrDone, irqAck, retiDone, irqRequest, irqHighLevel;
    logic [7:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [15:0] irqVector;
    src_vec_t srcEvent;
    int failCount, checked, cycles, ackCnt, c;
    reg_row_t regRows [10];
    vec_row_t vecRows [4];
    cpu_interrupt_handler i_cpu_interrupt_handler (.mclk, .rst, .address, .read, .write,
        .writedata, .byteenable(4'hF), .readdata, .waitrequest, .srcEvent, .extIrqA,
        .extIrqB, .instrDone, .irqAck, .retiDone, .irqRequest, .irqVector, .irqHighLevel);
    core_model #(.SVC(4)) i_core_model (.mclk, .rst, .irqRequest, .ackEn, .instrDone,
        .irqAck, .retiDone);
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic waitAck(input int k);
        for (int n = 0; n < 300 && ackCnt < k; n++)
            @(posedge mclk);
    endtask
    task automatic conclude;
        $display("counts: checked %0d bad %0d", checked, failCount);
        if (failCount == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cycles++;
        if (irqAck === 1'b1)
            ackCnt++;
        if (cycles == 8000)
        begin
            failCount++;
            conclude();
        end
    end
    initial
    begin
        {rst, ackEn, extIrqA, extIrqB} = 4'hB;
        {read, write, address, writedata, srcEvent} = '0;
        {failCount, checked, cycles, ackCnt} = '0;
        regRows = '{'{8'h08, 32'hFF, 32'h7F}, '{8'h0C, 32'hFF, 32'h7F}, '{8'h04, 32'hFF, 32'h7F},
            '{8'h00, 32'h7F, 32'h7F}, '{8'h14, 32'hFF, 32'h0F}, '{8'h1C, 32'hFF, 32'h00},
            '{8'h08, 32'h00, 32'h00}, '{8'h0C, 32'h00, 32'h00}, '{8'h04, 32'h00, 32'h00},
            '{8'h14, 32'h00, 32'h00}};
        vecRows = '{'{8'hE0, 8'h00, 8'h00, 32'h60, 16'h002B, 1'b0},
            '{8'hE0, 8'h00, 8'h40, 32'h60, 16'h0033, 1'b1},
            '{8'h80, 8'h02, 8'h00, 32'h100, 16'h004B, 1'b0},
            '{8'h80, 8'h40, 8'h00, 32'h2000, 16'h0073, 1'b0}};
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        foreach (regRows[i])
        begin
            bus(1'b0, regRows[i].a, 32'h0);
            `CMP(rd, 32'h0)
        end
        foreach (regRows[i])
        begin
            bus(1'b1, regRows[i].a, regRows[i].w);
            bus(1'b0, regRows[i].a, 32'h0);
            `CMP(rd, regRows[i].e)
        end
        foreach (vecRows[i])
        begin
            bus(1'b1, 8'h00, vecRows[i].e0);
            bus(1'b1, 8'h04, vecRows[i].e1);
            bus(1'b1, 8'h08, vecRows[i].p0);
            bus(1'b1, 8'h10, vecRows[i].pend);
            repeat (3) @(posedge mclk);
            `CMP(irqRequest, 1'b1)
            `CMP(irqVector, vecRows[i].vec)
            `CMP(irqHighLevel, vecRows[i].high)
        end
        $display("tables done");
        c = ackCnt;
        ackEn <= 1'b1;
        waitAck(c + 1);
        bus(1'b1, 8'h00, 32'hA0);
        bus(1'b1, 8'h08, 32'h20);
        bus(1'b1, 8'h10, 32'h2020);
        waitAck(c + 2);
        `CMP(ackCnt, c + 2)
        bus(1'b0, 8'h18, 32'h0);
        `CMP(rd[2:1], 2'b11)
        bus(1'b1, 8'h10, 32'h0);
        bus(1'b1, 8'h08, 32'h0);
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b1, 8'h00, 32'h10);
        repeat (60) @(posedge mclk);
        $display("preempt done");
        srcEvent[4] <= 1'b1;
        @(posedge mclk);
        srcEvent <= 14'h0000;
        repeat (8) @(posedge mclk);
        `CMP(irqRequest, 1'b0)
        bus(1'b0, 8'h10, 32'h0);
        `CMP(rd[4], 1'b1)
        c = ackCnt;
        bus(1'b1, 8'h00, 32'h90);
        waitAck(c + 1);
        bus(1'b0, 8'h10, 32'h0);
        `CMP(rd[4], 1'b1)
        waitAck(c + 2);
        `CMP(ackCnt, c + 2)
        bus(1'b1, 8'h10, 32'h0);
        repeat (60) @(posedge mclk);
        c = ackCnt;
        repeat (30) @(posedge mclk);
        `CMP(ackCnt, c)
        $display("retry done");
        ackEn <= 1'b0;
        bus(1'b1, 8'h00, 32'h0);
        for (int m = 0; m < 4; m++)
        begin
            extIrqA <= !m[1];
            bus(1'b1, 8'h14, {29'h0, m[1], 1'b0, m[0]});
            repeat (6) @(posedge mclk);
            bus(1'b1, 8'h10, 32'h0);
            extIrqA <= m[1];
            repeat (6) @(posedge mclk);
            bus(1'b0, 8'h10, 32'h0);
            `CMP(rd[0], 1'b1)
            extIrqA <= !m[1];
            repeat (6) @(posedge mclk);
            bus(1'b0, 8'h10, 32'h0);
            `CMP(rd[0], m[0])
        end
        bus(1'b1, 8'h14, 32'h2);
        repeat (6) @(posedge mclk);
        bus(1'b1, 8'h10, 32'h0);
        extIrqB <= 1'b0;
        repeat (6) @(posedge mclk);
        extIrqB <= 1'b1;
        bus(1'b0, 8'h10, 32'h0);
        `CMP(rd[2], 1'b1)
        c = ackCnt;
        bus(1'b1, 8'h00, 32'h84);
        repeat (3) @(posedge mclk);
        `CMP(irqVector, 16'h0013)
        ackEn <= 1'b1;
        waitAck(c + 1);
        bus(1'b0, 8'h10, 32'h0);
        `CMP(rd[2], 1'b0)
        $display("external done");
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        bus(1'b0, 8'h00, 32'h0);
        `CMP(rd, 32'h0)
        $display("reset done");
        conclude();
    end
endmodule
